// File: hw/srsc_pkg.sv
// Shared constants and types for the slice ram, shift and carry block
`default_nettype none
package srsc_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_QUAD = 8'h04;
    localparam logic [7:0] ADDR_DUAL = 8'h08;
    localparam logic [7:0] ADDR_SHIFT = 8'h0C;
    localparam logic [7:0] ADDR_CARRY = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    // Control field positions
    localparam int CTRL_RAM_CLK = 0;
    localparam int CTRL_RAM_INV = 1;
    localparam int CTRL_SHF_CLK = 2;
    localparam int CTRL_SHF_INV = 3;
    localparam int CTRL_RAM_WE = 4;
    localparam int CTRL_SHF_EN = 5;
    localparam int CTRL_SHF_DIN = 6;
    localparam int CTRL_SEL7_LO = 7;
    localparam int CTRL_SEL7_HI = 8;
    localparam int CTRL_SEL8 = 9;
    localparam int CTRL_CY_LSB = 10;
    localparam int CTRL_BYPASS = 12;
    localparam int CTRL_CASC_IN = 13;
    localparam int CTRL_CASC_USE = 14;
    localparam logic [31:0] CTRL_MASK = 32'h0000_7FFF;
    // Address and data field positions
    localparam int QUAD_WDATA_LSB = 20;
    localparam int DUAL_SECOND_LSB = 8;
    localparam int DUAL_DIN = 16;
    localparam int SINGLE_DIN = 17;
    localparam int SINGLE_ADDR_LSB = 24;
    localparam int CARRY_PROP_LSB = 4;
    localparam logic [31:0] QUAD_MASK = 32'h003F_FFFF;
    localparam logic [31:0] DUAL_MASK = 32'hFF03_3F3F;
    localparam logic [31:0] SHIFT_MASK = 32'h0000_001F;
    localparam logic [31:0] CARRY_MASK = 32'h0000_00FF;
    // Reset values
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    // Geometry
    localparam int QUAD_AW = 5;
    localparam int QUAD_DW = 2;
    localparam int QUAD_DEPTH = 32;
    localparam int DUAL_AW = 6;
    localparam int DUAL_DEPTH = 64;
    localparam int SINGLE_AW = 8;
    localparam int SINGLE_DEPTH = 256;
    localparam int SHIFT_AW = 5;
    localparam int SHIFT_LEN = 32;
    localparam int CARRY_W = 4;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    // First carry source
    typedef enum logic [1:0] {
        CARRY_ZERO = 2'b00,
        CARRY_ONE = 2'b01,
        CARRY_BYPASS = 2'b10,
        CARRY_SPARE = 2'b11
    } srsc_carry_init_type;
endpackage
`default_nettype wire

// File: hw/slice_ram_shift_carry.sv
// Slice building blocks: distributed ram, shift units, muxes, carry chain
`timescale 1ns/100ps
`default_nettype none

module srsc_shift_unit (
    // Clocking
    input wire logic clk,
    // Shift control
    input wire logic shiftStrobe,
    input wire logic serialIn,
    input wire logic [srsc_pkg::SHIFT_AW-1:0] stageAddr,
    // Taps
    output logic addressedOut,
    output logic cascadeTapOutput
);
    logic [srsc_pkg::SHIFT_LEN-1:0] stages_ff;

    // No reset term: contents survive any initialisation [R8]
    always_ff @(posedge clk) begin
        if (shiftStrobe) begin // [R9] [R10]
            stages_ff <= {stages_ff[srsc_pkg::SHIFT_LEN-2:0], serialIn};
        end
    end

    assign addressedOut = stages_ff[stageAddr]; // [R11] [R13]
    assign cascadeTapOutput = stages_ff[srsc_pkg::SHIFT_LEN-1]; // [R12]
endmodule // srsc_shift_unit

module srsc_mux_stage (
    // Data
    input wire logic dataFirst,
    input wire logic dataSecond,
    input wire logic sel,
    // Result
    output logic muxOut
);
    assign muxOut = sel ? dataSecond : dataFirst; // [R17]
endmodule // srsc_mux_stage

// Notes on behaviour
// R1: All memory ports read their own address from one shared array.
// R2: Write stores data at write address on active edge only when enabled.
// R3: Memory outputs follow their address; write port shows new data.
// R4: Memories span 32 words by 2 bits to 256 words by 1 bit.
// R5: Quad-port memory: three read-only addresses, fourth reads and writes.
// R6: Dual-port memory: primary address reads and writes, second only reads.
// R7: Memory and shift clocks each selectable rising or falling, rising default.
// R8: Initialisation never alters memory or shift contents.
// R9: Shift enable low: edge neither shifts nor loads.
// R10: Enabled edge loads serial input at stage zero, shifts all up.
// R11: Five-bit address picks stage 0 to 31 combinationally.
// R12: Cascade tap always shows stage 31, updated every shift.
// R13: Delay at addressed output equals address plus one.
// R14: User chains 72 stages via taps, last unit address 7 or 6.
// R15: User lowers address by one when registering the addressed output.
// R16: Four cascaded units through slice muxes give up to 128 stages.
// R17: Mux stage passes first input on select 0, second on 1.
// R18: Mux stages with lookups build 8-input to 16-input selectors.
// R19: Carry unit takes generate and propagate bits, gives sum and carry.
// R20: First carry is zero, one, or the bypass input.
// R21: User chains carry units by feeding top carry out to cascade in.
// R22: Sum is propagate xor carry; carry passes on propagate, else generate.
// R23: Cascade carry input overrides initial selection when not first.
module slice_ram_shift_carry (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);
    logic [31:0] ctrl_ff;
    logic [31:0] quad_ff;
    logic [31:0] dual_ff;
    logic [31:0] shift_ff;
    logic [31:0] carry_ff;
    logic wrPend_ff;
    logic rdPend_ff;
    logic [7:0] dataAddr_ff;
    logic hreadyout_ff;
    logic hresp_ff;
    logic [31:0] hrdata_ff;
    logic addrPhase;
    logic ctrlWrite;
    logic [31:0] nxt_ctrl;
    logic ramEdge;
    logic shiftEdge;
    logic [31:0] statusWord;
    logic [31:0] readValue;

    // Memory arrays
    logic [srsc_pkg::QUAD_DW-1:0] quadMem [srsc_pkg::QUAD_DEPTH];
    logic dualMem [srsc_pkg::DUAL_DEPTH];
    logic singleMem [srsc_pkg::SINGLE_DEPTH];

    // Memory port fields
    logic [srsc_pkg::QUAD_AW-1:0] quadReadAddressFirst;
    logic [srsc_pkg::QUAD_AW-1:0] quadReadAddressSecond;
    logic [srsc_pkg::QUAD_AW-1:0] quadReadAddressThird;
    logic [srsc_pkg::QUAD_AW-1:0] quadWriteAddress;
    logic [srsc_pkg::QUAD_DW-1:0] quadWriteData;
    logic quadWriteEnable;
    logic [srsc_pkg::QUAD_DW-1:0] quadOutFirst;
    logic [srsc_pkg::QUAD_DW-1:0] quadOutSecond;
    logic [srsc_pkg::QUAD_DW-1:0] quadOutThird;
    logic [srsc_pkg::QUAD_DW-1:0] quadWritePortOutput;
    logic [srsc_pkg::DUAL_AW-1:0] primaryAddress;
    logic [srsc_pkg::DUAL_AW-1:0] secondReadAddress;
    logic sharedPortOutput;
    logic secondPortOutput;
    logic [srsc_pkg::SINGLE_AW-1:0] singleAddress;
    logic singleOut;

    // Shift and mux wiring
    logic [3:0] unitIn;
    logic [3:0] unitOut;
    logic [3:0] unitTap;
    logic sliceMuxStageLower;
    logic sliceMuxStageUpper;
    logic sliceMuxStageTop;

    // Carry wiring
    logic [srsc_pkg::CARRY_W-1:0] generateInputs;
    logic [srsc_pkg::CARRY_W-1:0] propagateInputs;
    logic [srsc_pkg::CARRY_W-1:0] sumBits;
    logic [srsc_pkg::CARRY_W-1:0] carryOutBits;
    logic firstCarry;
    srsc_pkg::srsc_carry_init_type initialCarrySelect;

    // Bus acceptance: only whole-word transfers are served
    assign addrPhase = hsel && htrans[1] && hready &&
                       (hsize == srsc_pkg::HSIZE_WORD);

    always_ff @(posedge clk) begin
        if (rst) begin
            wrPend_ff <= 1'b0;
            rdPend_ff <= 1'b0;
            dataAddr_ff <= 8'h00;
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
        end else begin
            wrPend_ff <= addrPhase && hwrite;
            rdPend_ff <= addrPhase && !hwrite;
            if (addrPhase) begin
                dataAddr_ff <= (haddr[31:8] == 24'h00_0000) ?
                               haddr[7:0] : 8'hFF;
            end
            // One wait state on reads so status reflects the prior write
            hreadyout_ff <= !(addrPhase && !hwrite);
            hresp_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (rdPend_ff) begin
            hrdata_ff <= readValue;
        end
    end

    assign hreadyout = hreadyout_ff;
    assign hresp = hresp_ff;
    assign hrdata = hrdata_ff;

    // Register writes
    assign ctrlWrite = wrPend_ff && (dataAddr_ff == srsc_pkg::ADDR_CTRL);
    assign nxt_ctrl = ctrlWrite ? (hwdata & srsc_pkg::CTRL_MASK) : ctrl_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_ff <= srsc_pkg::REG_RESET;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            quad_ff <= srsc_pkg::REG_RESET;
            dual_ff <= srsc_pkg::REG_RESET;
            shift_ff <= srsc_pkg::REG_RESET;
            carry_ff <= srsc_pkg::REG_RESET;
        end else if (wrPend_ff) begin
            case (dataAddr_ff)
                srsc_pkg::ADDR_QUAD: begin
                    quad_ff <= hwdata & srsc_pkg::QUAD_MASK;
                end
                srsc_pkg::ADDR_DUAL: begin
                    dual_ff <= hwdata & srsc_pkg::DUAL_MASK;
                end
                srsc_pkg::ADDR_SHIFT: begin
                    shift_ff <= hwdata & srsc_pkg::SHIFT_MASK;
                end
                srsc_pkg::ADDR_CARRY: begin
                    carry_ff <= hwdata & srsc_pkg::CARRY_MASK;
                end
                default: begin
                end
            endcase
        end
    end

    // Edge of the soft clock levels; the invert bit picks the falling edge
    assign ramEdge = ctrlWrite &&
        (nxt_ctrl[srsc_pkg::CTRL_RAM_CLK] != ctrl_ff[srsc_pkg::CTRL_RAM_CLK])
        && (nxt_ctrl[srsc_pkg::CTRL_RAM_CLK] !=
            nxt_ctrl[srsc_pkg::CTRL_RAM_INV]); // [R7]
    assign shiftEdge = ctrlWrite &&
        (nxt_ctrl[srsc_pkg::CTRL_SHF_CLK] != ctrl_ff[srsc_pkg::CTRL_SHF_CLK])
        && (nxt_ctrl[srsc_pkg::CTRL_SHF_CLK] !=
            nxt_ctrl[srsc_pkg::CTRL_SHF_INV]); // [R7]

    // Memory fields
    assign quadReadAddressFirst = quad_ff[4:0];
    assign quadReadAddressSecond = quad_ff[9:5];
    assign quadReadAddressThird = quad_ff[14:10];
    assign quadWriteAddress = quad_ff[19:15];
    assign quadWriteData =
        quad_ff[srsc_pkg::QUAD_WDATA_LSB +: srsc_pkg::QUAD_DW];
    assign quadWriteEnable = nxt_ctrl[srsc_pkg::CTRL_RAM_WE];
    assign primaryAddress = dual_ff[5:0];
    assign secondReadAddress =
        dual_ff[srsc_pkg::DUAL_SECOND_LSB +: srsc_pkg::DUAL_AW];
    assign singleAddress =
        dual_ff[srsc_pkg::SINGLE_ADDR_LSB +: srsc_pkg::SINGLE_AW];

    // Writes carry no reset term [R8]
    always_ff @(posedge clk) begin
        if (ramEdge && quadWriteEnable) begin // [R2] [R5]
            quadMem[quadWriteAddress] <= quadWriteData;
            dualMem[primaryAddress] <= dual_ff[srsc_pkg::DUAL_DIN]; // [R6]
            singleMem[singleAddress] <= dual_ff[srsc_pkg::SINGLE_DIN]; // [R4]
        end
    end

    // Each port decodes its own address from the shared array [R1] [R3]
    assign quadOutFirst = quadMem[quadReadAddressFirst];
    assign quadOutSecond = quadMem[quadReadAddressSecond];
    assign quadOutThird = quadMem[quadReadAddressThird];
    assign quadWritePortOutput = quadMem[quadWriteAddress]; // [R5]
    assign sharedPortOutput = dualMem[primaryAddress]; // [R6]
    assign secondPortOutput = dualMem[secondReadAddress]; // [R6]
    assign singleOut = singleMem[singleAddress]; // [R4]

    // Four units chained tap to input: up to 128 stages [R16]
    assign unitIn = {unitTap[2:0], nxt_ctrl[srsc_pkg::CTRL_SHF_DIN]};

    genvar u;
    generate
        for (u = 0; u < 4; u++) begin : gUnit
            srsc_shift_unit addressable_shift_unit (
                .clk(clk),
                .shiftStrobe(shiftEdge &&
                             nxt_ctrl[srsc_pkg::CTRL_SHF_EN]), // [R9]
                .serialIn(unitIn[u]),
                .stageAddr(shift_ff[srsc_pkg::SHIFT_AW-1:0]),
                .addressedOut(unitOut[u]),
                .cascadeTapOutput(unitTap[u])
            );
        end
    endgenerate

    // Seven and eight stages form the slice selector tree [R16] [R18]
    srsc_mux_stage wide_mux_stage_seven_lower (
        .dataFirst(unitOut[0]),
        .dataSecond(unitOut[1]),
        .sel(ctrl_ff[srsc_pkg::CTRL_SEL7_LO]),
        .muxOut(sliceMuxStageLower)
    );

    srsc_mux_stage wide_mux_stage_seven_upper (
        .dataFirst(unitOut[2]),
        .dataSecond(unitOut[3]),
        .sel(ctrl_ff[srsc_pkg::CTRL_SEL7_HI]),
        .muxOut(sliceMuxStageUpper)
    );

    srsc_mux_stage wide_mux_stage_eight (
        .dataFirst(sliceMuxStageLower),
        .dataSecond(sliceMuxStageUpper),
        .sel(ctrl_ff[srsc_pkg::CTRL_SEL8]),
        .muxOut(sliceMuxStageTop)
    );

    // Carry chain
    assign generateInputs = carry_ff[srsc_pkg::CARRY_W-1:0];
    assign propagateInputs =
        carry_ff[srsc_pkg::CARRY_PROP_LSB +: srsc_pkg::CARRY_W];
    assign initialCarrySelect = srsc_pkg::srsc_carry_init_type'(
        ctrl_ff[srsc_pkg::CTRL_CY_LSB +: 2]);

    always_comb begin
        if (ctrl_ff[srsc_pkg::CTRL_CASC_USE]) begin
            firstCarry = ctrl_ff[srsc_pkg::CTRL_CASC_IN]; // [R23]
        end else begin
            case (initialCarrySelect) // [R20]
                srsc_pkg::CARRY_ZERO: firstCarry = 1'b0;
                srsc_pkg::CARRY_ONE: firstCarry = 1'b1;
                srsc_pkg::CARRY_BYPASS: begin
                    firstCarry = ctrl_ff[srsc_pkg::CTRL_BYPASS];
                end
                default: firstCarry = 1'b0;
            endcase
        end
    end

    always_comb begin
        logic c;
        c = firstCarry;
        sumBits = '0;
        carryOutBits = '0;
        for (int i = 0; i < srsc_pkg::CARRY_W; i++) begin // [R19]
            sumBits[i] = propagateInputs[i] ^ c; // [R22]
            carryOutBits[i] = propagateInputs[i] ? c : generateInputs[i];
            c = carryOutBits[i];
        end
    end

    // Status word shows live block state
    assign statusWord = {4'h0, carryOutBits, sumBits, 1'b0,
                         sliceMuxStageUpper, sliceMuxStageLower, unitTap[3],
                         sliceMuxStageTop, unitOut, singleOut,
                         secondPortOutput, sharedPortOutput,
                         quadWritePortOutput, quadOutThird, quadOutSecond,
                         quadOutFirst};

    always_comb begin
        case (dataAddr_ff)
            srsc_pkg::ADDR_CTRL: readValue = ctrl_ff;
            srsc_pkg::ADDR_QUAD: readValue = quad_ff;
            srsc_pkg::ADDR_DUAL: readValue = dual_ff;
            srsc_pkg::ADDR_SHIFT: readValue = shift_ff;
            srsc_pkg::ADDR_CARRY: readValue = carry_ff;
            srsc_pkg::ADDR_STATUS: readValue = statusWord;
            default: readValue = 32'h0000_0000;
        endcase
    end
endmodule // slice_ram_shift_carry

`default_nettype wire

// File: dv/srsc_asserts.sv
// Bus and status checks for the slice ram, shift and carry block
`timescale 1ns/100ps
`default_nettype none
module srsc_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bus inputs
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    // Bus outputs
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata
);
    logic take, rdTake, pw, c0;
    logic [7:0] pa;
    logic [31:0] ctl, cry;
    assign take = hsel && htrans[1] && hready && hsize == srsc_pkg::HSIZE_WORD;
    assign rdTake = take && !hwrite;
    assign c0 = ctl[14] ? ctl[13] :
                ctl[11:10] == 2'h1 || (ctl[11:10] == 2'h2 && ctl[12]);
    // Shadow copies of control and carry words, taken from the data phase
    always_ff @(posedge clk) begin
        if (rst) begin
            pw <= 1'b0;
        end else if (hready) begin
            pw <= take && hwrite && haddr[31:8] == 24'h0;
            pa <= haddr[7:0];
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            ctl <= 32'h0;
            cry <= 32'h0;
        end else if (hready && pw) begin
            if (pa == srsc_pkg::ADDR_CTRL) ctl <= hwdata;
            if (pa == srsc_pkg::ADDR_CARRY) cry <= hwdata;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence stRead;
        rdTake && haddr == {24'h0, srsc_pkg::ADDR_STATUS};
    endsequence
    sequence oneWait;
        !hreadyout ##1 hreadyout;
    endsequence
    resp_okay_a: assert property (!hresp) else $error("hresp not okay");
    read_wait_a: assert property (rdTake |=> oneWait)
        else $error("read wait wrong");
    write_nowait_a: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    wait_cause_a: assert property ($fell(hreadyout) |-> $past(rdTake))
        else $error("wait without read");
    data_hold_a: assert property (!$stable(hrdata) |-> !$past(hreadyout))
        else $error("hrdata moved");
    reset_idle_a: assert property (disable iff (1'b0)
        rst |=> hreadyout && hrdata == 32'h0) else $error("reset state wrong");
    carry_sum_a: assert property (stRead |-> ##2
        hrdata[23:20] == (cry[7:4] ^ {hrdata[26:24], c0}))
        else $error("sum bits wrong");
    carry_out_a: assert property (stRead |-> ##2
        hrdata[27:24] == ((cry[7:4] & {hrdata[26:24], c0}) |
                          (~cry[7:4] & cry[3:0])))
        else $error("carry bits wrong");
    first_carry_a: assert property (stRead |-> ##2
        hrdata[24] == (cry[4] ? c0 : cry[0])) else $error("first carry wrong");
    mux_lower_a: assert property (stRead |-> ##2
        hrdata[17] == (ctl[7] ? hrdata[12] : hrdata[11]))
        else $error("mux low");
    mux_upper_a: assert property (stRead |-> ##2
        hrdata[18] == (ctl[8] ? hrdata[14] : hrdata[13]))
        else $error("mux high");
    mux_top_a: assert property (stRead |-> ##2
        hrdata[15] == (ctl[9] ? hrdata[18] : hrdata[17]))
        else $error("mux top");
endmodule // srsc_asserts
bind slice_ram_shift_carry srsc_asserts u_chk (.clk(clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata));
`default_nettype wire

// File: dv/srsc_user_master.sv
// Bus master standing in for the user logic around the slice
`timescale 1ns/100ps
`default_nettype none
module srsc_user_master (
    // Clock
    input wire logic clk,
    // Request
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    // Answer
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = srsc_pkg::HSIZE_WORD;
        hwdata = 32'h0;
    end
    // Released lines flip so a stale value never passes for a live one
    task automatic xfer(input logic w, input logic [31:0] a, d,
                        output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hwdata <= ~hwdata;
        @(posedge clk);
        while (hready !== 1'b1)
            @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        haddr <= ~a;
        hwdata <= w ? d : ~hwdata;
        @(posedge clk);
        while (hready !== 1'b1)
            @(posedge clk);
        r = hrdata;
    endtask
endmodule // srsc_user_master
`default_nettype wire

// File: dv/slice_ram_shift_carry_tb.sv
// Self-checking bench for the slice ram, shift and carry block
`timescale 1ns/100ps
`default_nettype none
module slice_ram_shift_carry_tb;
    typedef struct packed {
        logic [31:0] c;
        logic [7:0] d;
        logic [7:0] e;
    } srsc_row_type;
    logic clk, rst, hsel, hwrite, hreadyout, hresp, lo, hi;
    logic [31:0] haddr, hwdata, hrdata, rdata, e;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] u;
    int fails = 0;
    int comparisons = 0;
    srsc_row_type rows [7] = '{'{32'h0000, 8'hF0, 8'h0F},
        '{32'h0400, 8'hF0, 8'hF0}, '{32'h1800, 8'h3C, 8'hFC},
        '{32'h0C00, 8'h3C, 8'hCB}, '{32'h4400, 8'hF0, 8'h0F},
        '{32'h6000, 8'hF0, 8'hF0}, '{32'h0800, 8'hF0, 8'h0F}};
    logic [7:0] regA [5] = '{srsc_pkg::ADDR_CTRL, srsc_pkg::ADDR_QUAD,
        srsc_pkg::ADDR_DUAL, srsc_pkg::ADDR_SHIFT, srsc_pkg::ADDR_CARRY};
    logic [31:0] regM [5] = '{srsc_pkg::CTRL_MASK, srsc_pkg::QUAD_MASK,
        srsc_pkg::DUAL_MASK, srsc_pkg::SHIFT_MASK, srsc_pkg::CARRY_MASK};
    logic [31:0] memCtl [4] = '{32'h11, 32'h10, 32'h01, 32'h12};
    logic [31:0] memExp [4] = '{32'h7AA, 32'h7AA, 32'h7AA, 32'h055};
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    srsc_user_master m (.clk(clk), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata));
    slice_ram_shift_carry dut (.clk(clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata));
    task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        m.xfer(1'b1, {24'h0, a}, d, r);
    endtask
    task automatic rdReg(input logic [7:0] a);
        m.xfer(1'b0, {24'h0, a}, 32'h0, rdata);
    endtask
    task automatic chk(input logic [31:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One shift per call: the active edge depends on the invert bit
    task automatic shift(input logic d, i, input logic [2:0] s);
        logic [31:0] w;
        w = {22'h0, s, d, 2'b10, i, 3'b100};
        wrReg(srsc_pkg::ADDR_CTRL, w);
        wrReg(srsc_pkg::ADDR_CTRL, w & 32'hFFFF_FFFB);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        fails++;
        wrap_up();
    end
    initial begin
        rst = 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            rdReg(regA[i]);
            chk(rdata, srsc_pkg::REG_RESET);
        end
        for (int k = 0; k < 128; k++)
            shift(1'b0, k[0], 3'h0);
        for (int i = 0; i < 5; i++) begin
            wrReg(regA[i], 32'hFFFF_FFFF);
            rdReg(regA[i]);
            chk(rdata, regM[i]);
        end
        wrReg(srsc_pkg::ADDR_CTRL, 32'h0);
        wrReg(8'h18, 32'hFFFF_FFFF);
        rdReg(8'h18);
        chk(rdata, 32'h0);
        $display("register test done");
        // Row 5 feeds cascade in as a lower unit's top carry would
        foreach (rows[i]) begin
            wrReg(srsc_pkg::ADDR_CTRL, rows[i].c);
            wrReg(srsc_pkg::ADDR_CARRY, {24'h0, rows[i].d});
            rdReg(srsc_pkg::ADDR_STATUS);
            chk(rdata & 32'h0FF0_0000,
                {4'h0, rows[i].e, 20'h0});
        end
        $display("carry test done");
        wrReg(srsc_pkg::ADDR_QUAD, 32'h0022_94A5);
        wrReg(srsc_pkg::ADDR_DUAL, 32'hFF03_3F3F);
        for (int i = 0; i < 4; i++) begin
            if (i == 1) begin
                wrReg(srsc_pkg::ADDR_QUAD, 32'h0012_94A5);
                wrReg(srsc_pkg::ADDR_DUAL, 32'hFF00_3F3F);
            end
            wrReg(srsc_pkg::ADDR_CTRL, memCtl[i]);
            rdReg(srsc_pkg::ADDR_STATUS);
            chk(rdata & 32'h07FF,
                memExp[i]);
        end
        $display("memory test done");
        wrReg(srsc_pkg::ADDR_SHIFT, 32'h3);
        for (int k = 1; k <= 128; k++) begin
            shift(k == 1, k[0], k[2:0]);
            u = {k == 100, k == 68, k == 36, k == 4};
            lo = k[0] ? u[1] : u[0];
            hi = k[1] ? u[3] : u[2];
            e = {13'h0, hi, lo, k == 128, k[2] ? hi : lo, u, 11'h0};
            rdReg(srsc_pkg::ADDR_STATUS);
            chk(rdata & 32'h0007_F800, e);
        end
        wrReg(srsc_pkg::ADDR_CTRL, 32'h04);
        wrReg(srsc_pkg::ADDR_CTRL, 32'h0);
        rdReg(srsc_pkg::ADDR_STATUS);
        chk(rdata & 32'h0001_0000, 32'h0001_0000);
        $display("shift test done");
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdReg(srsc_pkg::ADDR_STATUS);
        chk(rdata & 32'h0001_0000, 32'h0001_0000);
        rdReg(srsc_pkg::ADDR_CTRL);
        chk(rdata, srsc_pkg::REG_RESET);
        $display("second reset test done");
        wrap_up();
    end
endmodule // slice_ram_shift_carry_tb
`default_nettype wire
